//--- efc_defs.vh
// Purpose: constants for the embedded flash controller
// Assumes: plain Verilog-2005 include, guarded
// Notes: offsets are byte addresses on the register port
`ifndef EFC_DEFS_VH
`define EFC_DEFS_VH
// register offsets
`define EFC_OFS_MODE      8'h00
`define EFC_OFS_COMMAND   8'h04
`define EFC_OFS_STATUS    8'h08
`define EFC_OFS_LOCKS     8'h0c
// mode register fields
`define EFC_MODE_RDY_IE   0
`define EFC_MODE_LOCK_VIOLATION_FLAG_IE 2
`define EFC_MODE_COMMAND_ERROR_FLAG_IE 3
`define EFC_MODE_SKIP_AUTO_ERASE     7
`define EFC_MODE_FWS_LO   8
`define EFC_MODE_FWS_HI   9
`define EFC_MODE_MICROSECOND_CYCLE_COUNT_LO  16
`define EFC_MODE_MICROSECOND_CYCLE_COUNT_HI  23
`define EFC_MODE_RESET    32'h0000_0000
// command register fields
`define EFC_CMD_CODE_HI   3
`define EFC_CMD_PAGE_LO   8
`define EFC_CMD_PAGE_HI   17
`define EFC_CMD_KEY_LO    24
`define EFC_KEY           8'h5a
// command codes
`define EFC_CMD_WP        4'h1
`define EFC_CMD_SLB       4'h2
`define EFC_CMD_WPL       4'h3
`define EFC_CMD_CLB       4'h4
`define EFC_CMD_EA        4'h8
`define EFC_CMD_CMD_SET_GENERAL_BIT      4'hb
`define EFC_CMD_CMD_CLEAR_GENERAL_BIT      4'hd
`define EFC_CMD_SSB       4'hf
// status register fields
`define EFC_ST_RDY        0
`define EFC_ST_LOCK_VIOLATION_FLAG      2
`define EFC_ST_COMMAND_ERROR_FLAG      3
`define EFC_ST_SEC        4
`define EFC_ST_GENERAL_NVM_BITS_LO   8
// geometry: 1024 pages of 64 words, 16 lock regions of 64 pages
`define EFC_PAGE_W        10
`define EFC_WORD_W        6
`define EFC_REGION_W      4
`define EFC_NGP           3
// operation times in microseconds per microsecond tick
`define EFC_T_PAGE_US     16'd6000
`define EFC_T_ERASE_US    16'd15000
`define EFC_T_BIT_US      16'd1000
`endif

//--- efc_wait_timer.v
// Purpose: counts a programmed number of cycles, then pulses done
// Assumes: start is a single-cycle pulse
// Notes: load of zero finishes on the next edge
`timescale 1ns/100ps
module efc_wait_timer (
   clk,
   nrst,
   start,
   load,
   busy,
   done
);
   input             clk;
   input             nrst;
   input             start;
   input      [15:0] load;
   output reg        busy;
   output reg        done;
   reg        [15:0] cnt;

   // down counter; done pulses for one cycle when it hits zero
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt  <= load;
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt == 16'h0000) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt <= cnt - 16'h0001;
            end
         end
      end
   end
endmodule

//--- efc_flash_ctrl.v
// Purpose: flash controller: reads with prefetch, write latch, commands
// Assumes: one clock; register port answers reads one cycle later
// Notes: flash plane is modelled as an internal array
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "efc_defs.vh"
// Behaviour
// R01 - two 32-bit read buffers; next word fetched during second read
// R02 - read-ahead only for instruction fetches, never data reads
// R03 - read wait states 0..3; zero gives single-cycle reads
// R04 - one wait state: first sequential read waits, rest single cycle
// R05 - two or three: odd accesses take setting, even ones one cycle
// R06 - byte, halfword and word reads are all accepted
// R07 - reads wrap over the physical size across the region
// R08 - latch decodes low eight address bits only
// R09 - page-sized write-only latch reachable throughout the region
// R10 - masters write the latch only with full words
// R11 - latch writes take read setting plus one, except at three
// R12 - codes: write page 1, lock 2, write and lock 3, unlock 4
// R13 - codes: erase all 8, set gp bit b, clear gp bit d, security f
// R14 - command write clears ready; finishing the command sets it
// R15 - ready interrupt enable raises interrupt on command completion
// R16 - software puts the key in the top eight command bits
// R17 - bad key or code: array untouched, command error flag set
// R18 - write or erase in locked region: untouched, lock error set
// R19 - software programs microsecond cycle count before commands
// R20 - auto-erase before programming when skip bit clear
// R21 - skip bit set: program without erase, partial fills allowed
// R22 - lock regions of consecutive pages, each with own lock bit
// R23 - key 0x5a at bit 24, page or bit number in page field
// R24 - erase all refused with lock error if any region locked
// R25 - software waits for ready before the next command
module efc_flash_ctrl (
   clk,
   nrst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   mem_req,
   mem_we,
   mem_fetch,
   mem_size,
   mem_addr,
   mem_wdata,
   mem_ready,
   mem_rdata,
   irq
);
   input             clk;
   input             nrst;
   input      [7:0]  reg_addr;
   input      [31:0] reg_wdata;
   input             reg_wr;
   input             reg_rd;
   output reg [31:0] reg_rdata;
   input             mem_req;
   input             mem_we;
   input             mem_fetch;
   input      [1:0]  mem_size;
   input      [19:0] mem_addr;
   input      [31:0] mem_wdata;
   output reg        mem_ready;
   output reg [31:0] mem_rdata;
   output reg        irq;

   localparam NWORDS = 1 << (`EFC_PAGE_W + `EFC_WORD_W);
   localparam NPAGE_WORDS = 1 << `EFC_WORD_W;
   localparam NREG = 1 << `EFC_REGION_W;
   // one-hot states of the command sequencer
   localparam S_IDLE  = 4'b0001;
   localparam S_ERASE = 4'b0010;
   localparam S_PROG  = 4'b0100;
   localparam S_WAIT  = 4'b1000;

   reg [31:0] flash [0:NWORDS-1];
   reg [31:0] latch [0:NPAGE_WORDS-1];
   reg [31:0] mode;
   reg        op_ready_flag;
   reg        command_error_flag;
   reg        lock_violation_flag;
   reg        security;
   reg [NREG-1:0] locks;
   reg [`EFC_NGP-1:0] general_nvm_bits;
   reg [3:0]  state;
   reg [3:0]  op;
   reg [`EFC_PAGE_W-1:0] op_page;
   reg [`EFC_WORD_W:0]   widx;
   reg        erase_all_run;
   reg        tstart;
   reg [15:0] tload;
   wire       tdone;
   // read path
   reg [1:0]  acc_cnt;
   reg        acc_busy;
   reg        acc_wr;
   reg [19:0] acc_addr;
   reg [31:0] buf0;
   reg [31:0] buf1;
   reg [17:0] buf0_tag;
   reg [17:0] buf1_tag;
   reg        buf0_ok;
   reg        buf1_ok;
   reg        seq_odd;
   reg [17:0] last_word;
   reg        last_ok;
   integer    i;

   wire [1:0]  read_wait_states = mode[`EFC_MODE_FWS_HI:`EFC_MODE_FWS_LO];
   wire [7:0]  microsecond_cycle_count =
      mode[`EFC_MODE_MICROSECOND_CYCLE_COUNT_HI:`EFC_MODE_MICROSECOND_CYCLE_COUNT_LO];
   wire        skip_auto_erase = mode[`EFC_MODE_SKIP_AUTO_ERASE];
   wire [7:0]  key = reg_wdata[31:`EFC_CMD_KEY_LO];
   wire [3:0]  command_code_field = reg_wdata[`EFC_CMD_CODE_HI:0];
   wire [`EFC_PAGE_W-1:0] page_number_field =
      reg_wdata[`EFC_CMD_PAGE_HI:`EFC_CMD_PAGE_LO];
   wire [`EFC_REGION_W-1:0] tgt_region =
      page_number_field[`EFC_PAGE_W-1:`EFC_PAGE_W-`EFC_REGION_W];
   wire cmd_wr = reg_wr && (reg_addr == `EFC_OFS_COMMAND);
   wire code_ok = (command_code_field == `EFC_CMD_WP) ||
                  (command_code_field == `EFC_CMD_SLB) ||
                  (command_code_field == `EFC_CMD_WPL) ||
                  (command_code_field == `EFC_CMD_CLB) ||
                  (command_code_field == `EFC_CMD_EA) ||
                  (command_code_field == `EFC_CMD_CMD_SET_GENERAL_BIT) ||
                  (command_code_field == `EFC_CMD_CMD_CLEAR_GENERAL_BIT) ||
                  (command_code_field == `EFC_CMD_SSB);
   wire is_write = (command_code_field == `EFC_CMD_WP) ||
                   (command_code_field == `EFC_CMD_WPL);
   wire key_ok = (key == `EFC_KEY);
   wire bad_cmd = cmd_wr && (!key_ok || !code_ok);
   wire lock_hit = cmd_wr && key_ok && code_ok &&
      ((is_write && locks[tgt_region]) ||
       (command_code_field == `EFC_CMD_EA && (|locks)));
   wire go_cmd = cmd_wr && key_ok && code_ok && !lock_hit &&
                 (state == S_IDLE);
   wire st_rd = reg_rd && (reg_addr == `EFC_OFS_STATUS);
   wire [15:0] us_cycles = {8'h00, microsecond_cycle_count} + 16'h0001;

   // operation timer counts microsecond ticks scaled by the cycle count
   efc_wait_timer u_timer (
      .clk   (clk),
      .nrst  (nrst),
      .start (tstart),
      .load  (tload),
      .busy  (),
      .done  (tdone)
   );

   // mode register and register read port
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode      <= `EFC_MODE_RESET;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == `EFC_OFS_MODE)
            mode <= reg_wdata;
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `EFC_OFS_MODE: reg_rdata <= mode;
               `EFC_OFS_STATUS: begin
                  reg_rdata[`EFC_ST_RDY]   <= op_ready_flag;
                  reg_rdata[`EFC_ST_LOCK_VIOLATION_FLAG] <= lock_violation_flag;
                  reg_rdata[`EFC_ST_COMMAND_ERROR_FLAG] <= command_error_flag;
                  reg_rdata[`EFC_ST_SEC]   <= security;
                  reg_rdata[`EFC_ST_GENERAL_NVM_BITS_LO+`EFC_NGP-1:`EFC_ST_GENERAL_NVM_BITS_LO]
                     <= general_nvm_bits;
                  reg_rdata[31:16] <= {{(16-NREG){1'b0}}, locks};
               end
               `EFC_OFS_LOCKS: reg_rdata <= {{(32-NREG){1'b0}}, locks};
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // error flags: a new error in the same cycle as a status read wins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         command_error_flag  <= 1'b0;
         lock_violation_flag <= 1'b0;
      end else begin
         if (bad_cmd)
            command_error_flag <= 1'b1; // R17
         else if (st_rd)
            command_error_flag <= 1'b0; // R17
         if (lock_hit)
            lock_violation_flag <= 1'b1; // R18 R24
         else if (st_rd)
            lock_violation_flag <= 1'b0; // R18
      end
   end

   // command sequencer: erase, program, nvm bit updates
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state            <= S_IDLE;
         op               <= 4'h0;
         op_page          <= {`EFC_PAGE_W{1'b0}};
         widx             <= {(`EFC_WORD_W+1){1'b0}};
         op_ready_flag    <= 1'b1;
         locks            <= {NREG{1'b0}};
         general_nvm_bits <= {`EFC_NGP{1'b0}};
         security         <= 1'b0;
         erase_all_run    <= 1'b0;
         tstart           <= 1'b0;
         tload            <= 16'h0000;
         irq              <= 1'b0;
      end else begin
         tstart <= 1'b0;
         irq    <= 1'b0;
         case (state)
            S_IDLE: begin
               if (go_cmd) begin
                  op_ready_flag <= 1'b0; // R14
                  op      <= command_code_field;
                  op_page <= page_number_field; // R23
                  widx    <= {(`EFC_WORD_W+1){1'b0}};
                  tstart  <= 1'b1;
                  if (is_write && !skip_auto_erase) begin
                     state <= S_ERASE; // R20
                     tload <= us_cycles * `EFC_T_BIT_US;
                  end else if (is_write) begin
                     state <= S_PROG; // R21
                     tload <= us_cycles * `EFC_T_PAGE_US;
                  end else begin
                     state <= S_WAIT;
                     erase_all_run <= (command_code_field == `EFC_CMD_EA);
                     tload <= (command_code_field == `EFC_CMD_EA) ?
                        us_cycles * `EFC_T_ERASE_US :
                        us_cycles * `EFC_T_BIT_US; // R19
                  end
               end
            end
            S_ERASE: begin
               // clear the target page one word per cycle
               if (!widx[`EFC_WORD_W]) begin
                  flash[{op_page, widx[`EFC_WORD_W-1:0]}] <= 32'hffff_ffff;
                  widx <= widx + 1'b1;
               end else if (tdone) begin
                  widx   <= {(`EFC_WORD_W+1){1'b0}};
                  state  <= S_PROG;
                  tstart <= 1'b1;
                  tload  <= us_cycles * `EFC_T_PAGE_US;
               end
            end
            S_PROG: begin
               // programming only pulls bits low, so partial fills work
               if (!widx[`EFC_WORD_W]) begin
                  flash[{op_page, widx[`EFC_WORD_W-1:0]}] <=
                     flash[{op_page, widx[`EFC_WORD_W-1:0]}] &
                     latch[widx[`EFC_WORD_W-1:0]];
                  widx <= widx + 1'b1;
               end else if (tdone) begin
                  if (op == `EFC_CMD_WPL)
                     locks[op_page[`EFC_PAGE_W-1:`EFC_PAGE_W-`EFC_REGION_W]]
                        <= 1'b1; // R22
                  state         <= S_IDLE;
                  op_ready_flag <= 1'b1; // R14
                  irq           <= mode[`EFC_MODE_RDY_IE]; // R15
               end
            end
            S_WAIT: begin
               if (erase_all_run) begin
                  for (i = 0; i < NWORDS; i = i + 1)
                     flash[i] <= 32'hffff_ffff;
                  erase_all_run <= 1'b0;
               end
               if (tdone) begin
                  case (op)
                     `EFC_CMD_SLB: locks[op_page[`EFC_PAGE_W-1:
                        `EFC_PAGE_W-`EFC_REGION_W]] <= 1'b1; // R12 R22
                     `EFC_CMD_CLB: locks[op_page[`EFC_PAGE_W-1:
                        `EFC_PAGE_W-`EFC_REGION_W]] <= 1'b0; // R12
                     `EFC_CMD_CMD_SET_GENERAL_BIT: if (op_page < `EFC_NGP)
                        general_nvm_bits[op_page[1:0]] <= 1'b1; // R13
                     `EFC_CMD_CMD_CLEAR_GENERAL_BIT: if (op_page < `EFC_NGP)
                        general_nvm_bits[op_page[1:0]] <= 1'b0; // R13
                     `EFC_CMD_SSB: security <= 1'b1; // R13
                     default: security <= security;
                  endcase
                  state         <= S_IDLE;
                  op_ready_flag <= 1'b1; // R14
                  irq           <= mode[`EFC_MODE_RDY_IE]; // R15
               end
            end
            default: state <= S_IDLE;
         endcase
         // error events also raise the line when their enables are set
         if (lock_hit && mode[`EFC_MODE_LOCK_VIOLATION_FLAG_IE])
            irq <= 1'b1;
         if (bad_cmd && mode[`EFC_MODE_COMMAND_ERROR_FLAG_IE])
            irq <= 1'b1;
      end
   end

   // latch writes decode only the low eight address bits
   always @(posedge clk) begin
      if (mem_req && mem_we && !acc_busy)
         latch[mem_addr[7:2]] <= mem_wdata; // R08 R09 R10
   end

   // bus access timing and read-ahead buffers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_cnt   <= 2'b00;
         acc_busy  <= 1'b0;
         acc_wr    <= 1'b0;
         acc_addr  <= 20'h00000;
         mem_ready <= 1'b0;
         mem_rdata <= 32'h0000_0000;
         buf0 <= 32'h0000_0000;
         buf1 <= 32'h0000_0000;
         buf0_tag <= 18'h00000;
         buf1_tag <= 18'h00000;
         buf0_ok <= 1'b0;
         buf1_ok <= 1'b0;
         seq_odd <= 1'b0;
         last_word <= 18'h00000;
         last_ok <= 1'b0;
      end else begin
         mem_ready <= 1'b0;
         if (mem_req && !acc_busy && !mem_ready) begin
            acc_addr <= mem_addr;
            acc_wr   <= mem_we;
            last_word <= mem_addr[19:2];
            last_ok   <= !mem_we && mem_fetch;
            if (mem_we) begin
               acc_busy <= 1'b1;
               acc_cnt  <= (read_wait_states == 2'd3) ? 2'd3 :
                           read_wait_states + 2'd1; // R11
            end else if (mem_fetch && last_ok &&
                         mem_addr[19:2] == last_word + 18'h00001) begin
               // sequential fetch: buffered word or alternate timing
               seq_odd <= !seq_odd;
               if ((read_wait_states <= 2'd1) ||
                   (read_wait_states != 2'd0 && seq_odd) ||
                   (buf1_ok && buf1_tag == mem_addr[19:2])) begin
                  mem_ready <= 1'b1; // R04 R05
                  mem_rdata <= flash[mem_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]];
                  buf0 <= flash[mem_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]];
                  buf0_tag <= mem_addr[19:2];
                  buf0_ok  <= 1'b1;
               end else begin
                  acc_busy <= 1'b1;
                  acc_cnt  <= read_wait_states; // R05
               end
            end else begin
               seq_odd <= 1'b1;
               if (read_wait_states == 2'd0) begin
                  mem_ready <= 1'b1; // R03
                  mem_rdata <= flash[mem_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]];
               end else begin
                  acc_busy <= 1'b1;
                  acc_cnt  <= read_wait_states; // R03 R04
               end
            end
         end else if (acc_busy) begin
            if (acc_cnt <= 2'd1) begin
               acc_busy  <= 1'b0;
               mem_ready <= 1'b1;
               if (!acc_wr) begin
                  // full word returned; byte lanes picked by the master
                  mem_rdata <=
                     flash[acc_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]]; // R06 R07
                  if (last_ok) begin
                     buf0 <= flash[acc_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]];
                     buf0_tag <= acc_addr[19:2];
                     buf0_ok  <= 1'b1;
                     buf1 <= flash[acc_addr[`EFC_PAGE_W+`EFC_WORD_W+1:2]
                                   + 1'b1]; // R01 R02
                     buf1_tag <= acc_addr[19:2] + 18'h00001;
                     buf1_ok  <= 1'b1;
                  end
               end
            end else begin
               acc_cnt <= acc_cnt - 2'd1;
            end
         end
         if (state != S_IDLE) begin
            buf0_ok <= 1'b0;
            buf1_ok <= 1'b0;
         end
      end
   end
endmodule

//--- efc_flash_ctrl_props.sv
// Purpose: port checks for the flash controller
// Assumes: one access outstanding, a gap cycle between accesses
// Notes: the mode register is shadowed to know the wait states
`timescale 1ns/100ps
`include "efc_defs.vh"
module efc_props (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_fetch,
   input wire logic [1:0]  mem_size,
   input wire logic [19:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ready,
   input wire logic [31:0] mem_rdata,
   input wire logic        irq
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [1:0]  ws;
   logic [7:0]  ie;
   logic        req_d, we_c, fe_c, seq, slow, fe_l;
   logic [19:0] adr_l;
   logic [3:0]  cnt;
   wire start   = mem_req & ~req_d;
   wire seq_now = mem_fetch & fe_l & (mem_addr == adr_l + 20'h4);
   wire rd_done = mem_ready & ~we_c;
   wire st_rd   = reg_rd && reg_addr == `EFC_OFS_STATUS;
   wire bad_cmd = reg_wr && reg_addr == `EFC_OFS_COMMAND
                  && reg_wdata[31:24] != `EFC_KEY;
   // latency counter; a run restarts on any non-sequential access
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {ws, ie, req_d, we_c, fe_c, seq, slow, fe_l} <= 16'h0000;
         adr_l <= 20'h0;
         cnt <= 4'h0;
      end else begin
         req_d <= mem_req;
         if (reg_wr && reg_addr == `EFC_OFS_MODE) begin
            ws <= reg_wdata[9:8];
            ie <= reg_wdata[7:0];
         end
         if (start) begin
            cnt <= 4'h1;
            we_c <= mem_we;
            fe_c <= mem_fetch;
            seq <= seq_now;
            slow <= ~(seq_now & slow);
            fe_l <= mem_fetch & ~mem_we;
            adr_l <= mem_addr;
         end else if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
   AST_WS_ZERO: assert property (rd_done && ws == 2'h0 |-> cnt == 4'h1)
      else $error("zero wait read not single cycle");
   AST_WS_ONE: assert property (rd_done && fe_c && ws == 2'h1
      |-> cnt == (seq ? 4'h1 : 4'h2)) else $error("one wait fetch timing");
   AST_WS_ALT: assert property (rd_done && fe_c && ws[1]
      |-> cnt == (slow ? {2'h0, ws} + 4'h1 : 4'h1))
      else $error("alternating fetch timing wrong");
   AST_DATA_NOPF: assert property (rd_done && !fe_c
      |-> cnt == {2'h0, ws} + 4'h1) else $error("data read was prefetched");
   AST_WR_WAIT: assert property (mem_ready && we_c
      |-> cnt == (ws == 2'h3 ? 4'h4 : {2'h0, ws} + 4'h2))
      else $error("latch write wait wrong");
   AST_IRQ_EN: assert property (irq |-> ie[0] | ie[2] | ie[3])
      else $error("interrupt without enable");
   AST_BAD_KEY: assert property (bad_cmd ##2 st_rd |=> reg_rdata[3])
      else $error("bad key did not flag");
   AST_FLAG_CLR: assert property (st_rd ##1 !reg_wr ##1 st_rd
      |=> reg_rdata[3:2] == 2'h0) else $error("error flag not cleared");
   cover property (rd_done && fe_c && ws == 2'h3 && !slow);
   cover property (mem_ready && we_c && ws == 2'h3);
   cover property (irq);
endmodule
bind efc_flash_ctrl efc_props chk_u (.*);

//--- efc_bus_master.sv
// Purpose: processor-side master on the flash access port
// Assumes: one access at a time, request held until ready
// Notes: address and data invert when idle so stale values show
`timescale 1ns/100ps
module efc_bus_master (
   input  wire logic        clk,
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_fetch,
   output logic [1:0]       mem_size,
   output logic [19:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ready,
   input  wire logic [31:0] mem_rdata
);
   initial begin
      {mem_req, mem_we, mem_fetch} = 3'h0;
      mem_size = 2'h2;
      mem_addr = 20'h0;
      mem_wdata = 32'h0;
   end
   // qualifiers stay put until the edge that samples ready
   task automatic access(input logic we, input logic fe,
      input logic [1:0] sz, input logic [19:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output int lat);
      lat = 0;
      mem_req <= 1'b1;
      mem_we <= we;
      mem_fetch <= fe;
      mem_size <= we ? 2'h2 : sz;
      mem_addr <= a;
      mem_wdata <= wd;
      @(posedge clk);
      do begin
         @(posedge clk);
         lat++;
      end while (mem_ready !== 1'b1 && lat < 16);
      rd = mem_rdata;
      mem_req <= 1'b0;
      mem_addr <= ~a;
      mem_wdata <= ~wd;
      @(posedge clk);
   endtask
endmodule

//--- efc_flash_ctrl_tb.sv
// Purpose: self-checking bench for the flash controller
// Assumes: microsecond count zero keeps operations short
// Notes: erased words are taken to read as all ones
`timescale 1ns/100ps
`include "efc_defs.vh"
module efc_flash_ctrl_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire  [31:0] reg_rdata, mem_rdata, mem_wdata;
   wire         mem_req, mem_we, mem_fetch, mem_ready, irq;
   wire  [1:0]  mem_size;
   wire  [19:0] mem_addr;
   int          error_cnt = 0, total_checks = 0, irq_cnt = 0, lat;
   logic [31:0] rd, st, pg [64];
   logic [19:0] a;
   logic [9:0]  pn;
   efc_flash_ctrl dut_u (.*);
   efc_bus_master bm_u (.*);
   always #5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_cnt++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_lat(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         error_cnt++;
         $display("[ERR] t=%0t lat got=%h exp=%h", $time, got, exp);
      end
   endtask
   // at two or three waits, odd accesses of a run pay the full wait, even ones are prefetched; at one, only the first waits
   function automatic int fetch_lat(input int ws, input int k);
      if (ws < 2) return (ws == 1 && k == 0) ? 2 : 1;
      return (k % 2) ? 1 : ws + 1;
   endfunction
   // a spare cycle after each strobe keeps drivers race free
   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] ad);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rd = reg_rdata;
   endtask
   task automatic acc(input logic we, fe, input logic [19:0] ad,
      input logic [31:0] wd);
      bm_u.access(we, fe, 2'($urandom % 3), ad, wd, rd, lat);
   endtask
   task automatic mode(input logic [1:0] ws, input logic skip);
      wr_reg(`EFC_OFS_MODE, {16'h0, 6'h0, ws, skip, 6'h0, 1'b1});
   endtask
   // issue, look for busy at once, then poll until ready returns
   task automatic cmd(input logic [3:0] code, input logic [9:0] p,
      input bit ok);
      int n, i0;
      i0 = irq_cnt;
      wr_reg(`EFC_OFS_COMMAND, {`EFC_KEY, 6'h0, p, 4'h0, code});
      rd_reg(`EFC_OFS_STATUS);
      st = rd;
      if (ok) chk({31'h0, rd[0]}, 32'h0);
      n = 0;
      while (rd[0] !== 1'b1 && n < 10000) begin
         rd_reg(`EFC_OFS_STATUS);
         n++;
      end
      chk({31'h0, rd[0]}, 32'h1);
      if (ok) chk_lat(irq_cnt - i0, 1);
   endtask
   // latch written at scattered addresses, page read back with wrap
   task automatic prog(input logic [9:0] p, input bit andw);
      logic [31:0] d;
      for (int w = 0; w < 64; w++) begin
         d = $urandom;
         pg[w] = andw ? pg[w] & d : d;
         acc(1'b1, 1'b0, {12'($urandom), 6'(w), 2'h0}, d);
      end
      cmd(`EFC_CMD_WP, p, 1);
      for (int w = 0; w < 64; w++) begin
         acc(1'b0, 1'b0, {2'(w), p, 6'(w), 2'h0}, 32'h0);
         chk(rd, pg[w]);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #900000;
      error_cnt++;
      final_report();
   end
   initial begin
      void'($urandom(92));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(`EFC_OFS_STATUS);
      chk({31'h0, rd[0]}, 32'h1);
      for (int ws = 0; ws < 4; ws++) begin
         mode(2'(ws), 1'b0);
         a = 20'($urandom) & 20'hfffc0;
         for (int k = 0; k < 4; k++) begin
            acc(1'b0, 1'b1, a + 20'(4 * k), 32'h0);
            chk_lat(lat, fetch_lat(ws, k));
         end
         for (int k = 0; k < 2; k++) begin
            acc(1'b0, 1'b0, a + 20'(4 * k), 32'h0);
            chk_lat(lat, ws + 1);
         end
         acc(1'b1, 1'b0, a, $urandom);
         chk_lat(lat, ws == 3 ? 4 : ws + 2);
      end
      mode(2'h0, 1'b0);
      pn = 10'($urandom);
      prog(pn, 1'b0);
      prog(pn, 1'b0);
      cmd(`EFC_CMD_SLB, pn, 1);
      rd_reg(`EFC_OFS_STATUS);
      chk({31'h0, rd[16 + pn[9:6]]}, 32'h1);
      cmd(`EFC_CMD_WP, pn ^ 10'h1, 0);
      chk({31'h0, st[2]}, 32'h1);
      cmd(`EFC_CMD_EA, pn, 0);
      chk({31'h0, st[2]}, 32'h1);
      acc(1'b0, 1'b0, {2'h0, pn, 8'h00}, 32'h0);
      chk(rd, pg[0]);
      cmd(`EFC_CMD_CLB, pn, 1);
      chk({31'h0, rd[16 + pn[9:6]]}, 32'h0);
      cmd(`EFC_CMD_WPL, pn, 1);
      chk({31'h0, rd[16 + pn[9:6]]}, 32'h1);
      cmd(`EFC_CMD_CLB, pn, 1);
      wr_reg(`EFC_OFS_COMMAND, {8'ha5, 6'h0, pn, 4'h0, `EFC_CMD_EA});
      rd_reg(`EFC_OFS_STATUS);
      chk({31'h0, rd[3]}, 32'h1);
      wr_reg(`EFC_OFS_COMMAND, {`EFC_KEY, 6'h0, pn, 8'h05});
      rd_reg(`EFC_OFS_STATUS);
      chk({31'h0, rd[3]}, 32'h1);
      rd_reg(`EFC_OFS_STATUS);
      chk({31'h0, rd[3]}, 32'h0);
      acc(1'b0, 1'b0, {2'h0, pn, 8'h04}, 32'h0);
      chk(rd, pg[1]);
      cmd(`EFC_CMD_CMD_SET_GENERAL_BIT, 10'h1, 1);
      chk({31'h0, rd[9]}, 32'h1);
      cmd(`EFC_CMD_CMD_CLEAR_GENERAL_BIT, 10'h1, 1);
      chk({31'h0, rd[9]}, 32'h0);
      cmd(`EFC_CMD_SSB, 10'h0, 1);
      chk({31'h0, rd[4]}, 32'h1);
      cmd(`EFC_CMD_EA, 10'h0, 1);
      for (int w = 0; w < 64; w++) pg[w] = 32'hffff_ffff;
      mode(2'h0, 1'b1);
      prog(pn, 1'b1);
      prog(pn, 1'b1);
      final_report();
   end
endmodule
